// [hw/ptma_array.v]
// The register addresses and the AXI4-Lite slave port are this design's own decisions.
`include "ptma_map.vh"

module ptma_array #(
  parameter NIN = 32,
  parameter NFB = 9,
  parameter NMC = 16
) (
  input  wire           aclk,
  input  wire           aresetn,
  input  wire [NIN-1:0] local_in,
  input  wire [1:0]     dev_clk_pin,
  input  wire [1:0]     glb_sig,
  input  wire [5:0]     loc_ctl,
  output reg  [NMC-1:0] mc_out,
  input  wire [11:0]    s_axi_awaddr,
  input  wire           s_axi_awvalid,
  output reg            s_axi_awready,
  input  wire [31:0]    s_axi_wdata,
  input  wire [3:0]     s_axi_wstrb,
  input  wire           s_axi_wvalid,
  output reg            s_axi_wready,
  output reg  [1:0]     s_axi_bresp,
  output reg            s_axi_bvalid,
  input  wire           s_axi_bready,
  input  wire [11:0]    s_axi_araddr,
  input  wire           s_axi_arvalid,
  output reg            s_axi_arready,
  output reg  [31:0]    s_axi_rdata,
  output reg  [1:0]     s_axi_rresp,
  output reg            s_axi_rvalid,
  input  wire           s_axi_rready
);

  localparam NT = 2 * NMC;
  localparam NW = 4 * NT;

  // ************************************************************
  // Configuration storage
  // ************************************************************
  reg [31:0] mc_cfg [0:NMC-1];
  reg [31:0] term_mem [0:NW-1];
  reg [31:0] clk_cfg;
  reg [31:0] clr_cfg;

  // ************************************************************
  // Input synchronisers
  // ************************************************************
  reg [NIN-1:0] in_s1;
  reg [NIN-1:0] in_s2;
  reg [9:0]     ctl_s1;
  reg [9:0]     ctl_s2;
  reg [1:0]     clk_prev;

  // Two-stage capture of every pin-side signal
  always @(posedge aclk) begin
    if (!aresetn) begin
      in_s1  <= {NIN{1'b0}};
      in_s2  <= {NIN{1'b0}};
      ctl_s1 <= 10'h000;
      ctl_s2 <= 10'h000;
    end else begin
      in_s1  <= local_in;
      in_s2  <= in_s1;
      ctl_s1 <= {loc_ctl, glb_sig, dev_clk_pin};
      ctl_s2 <= ctl_s1;
    end
  end

  wire [1:0] pin_s = ctl_s2[1:0];
  wire [1:0] glb_s = ctl_s2[3:2];
  wire [5:0] loc_s = ctl_s2[9:4];

  // ************************************************************
  // Block clocks, enables and clears
  // ************************************************************
  reg  [1:0] blk_clk;
  reg  [1:0] blk_clr;
  wire [1:0] blk_tick;

  // Clock source and clear source selection
  always @* begin : ctl_sel
    integer n;
    reg [1:0] src;
    reg       raw;
    src = 2'h0;
    raw = 1'b0;
    for (n = 0; n < 2; n = n + 1) begin
      src = clk_cfg[n*`PTMA_CK_SRC_W +: 2];
      case (src)
        `PTMA_SRC_PIN: blk_clk[n] = pin_s[n];
        `PTMA_SRC_GLB: blk_clk[n] = glb_s[n];
        `PTMA_SRC_LOC: blk_clk[n] = loc_s[n];
        default:       blk_clk[n] = 1'b0;
      endcase
      raw = clr_cfg[n*`PTMA_CL_W + `PTMA_CL_LOCAL] ? loc_s[4+n] : glb_s[n];
      blk_clr[n] = raw ^ clr_cfg[n*`PTMA_CL_W + `PTMA_CL_INV];
    end
  end

  // Previous clock level for edge detection
  always @(posedge aclk) begin
    if (!aresetn) begin
      clk_prev <= 2'b00;
    end else begin
      clk_prev <= blk_clk;
    end
  end

  // Active edge per block clock, gated by its paired enable
  genvar c;
  generate
    for (c = 0; c < 2; c = c + 1) begin : g_clk
      wire fall = clk_cfg[c*`PTMA_CK_SRC_W + `PTMA_CK_FALL];
      wire edge_seen = fall ? (clk_prev[c] & ~blk_clk[c]) : (~clk_prev[c] & blk_clk[c]);
      assign blk_tick[c] = edge_seen & loc_s[2+c];
    end
  endgenerate

  // ************************************************************
  // Product terms
  // ************************************************************
  wire [NIN+NFB-1:0] term_in = {mc_out[NFB-1:0], in_s2};
  wire [NT-1:0]      term;

  // Each term ANDs true and complemented literals; empty term is off
  genvar t;
  generate
    for (t = 0; t < NT; t = t + 1) begin : g_term
      wire [NIN+NFB-1:0] tmask = {term_mem[4*t+2][NFB-1:0], term_mem[4*t][NIN-1:0]};
      wire [NIN+NFB-1:0] cmask = {term_mem[4*t+3][NFB-1:0], term_mem[4*t+1][NIN-1:0]};
      wire used = |(tmask | cmask);
      assign term[t] = used & (&(~tmask | term_in)) & (&(~cmask | ~term_in));
    end
  endgenerate

  // ************************************************************
  // Term select matrix, expander chain and macrocells
  // ************************************************************
  wire [NMC:0]   exp_chain;
  wire [NMC-1:0] mc_q;
  assign exp_chain[NMC] = 1'b0;

  genvar m;
  generate
    for (m = 0; m < NMC; m = m + 1) begin : g_mc
      wire [31:0] cfg = mc_cfg[m];
      // Own terms, the second one optionally inverted
      wire t0 = term[2*m];
      wire t1 = term[2*m+1] ^ cfg[`PTMA_MC_INV1];
      wire lend0 = cfg[`PTMA_MC_LEND0];
      wire lend1 = cfg[`PTMA_MC_LEND1];
      wire lent = (lend0 & t0) | (lend1 & t1);
      // Lent terms join the chain heading to lower macrocells
      assign exp_chain[m] = lent | (cfg[`PTMA_MC_PASS] & exp_chain[m+1]);
      // Terms kept at home feed the own OR
      wire prim = (~lend0 & t0) | (~lend1 & t1);
      wire sum = prim | (cfg[`PTMA_MC_TAKE] & exp_chain[m+1]);
      wire logic_out = sum ^ cfg[`PTMA_MC_XOR];
      // Clock and clear selection for this macrocell
      wire ck = cfg[`PTMA_MC_CLKSEL];
      wire [1:0] cs = cfg[`PTMA_MC_CLR_HI:`PTMA_MC_CLR_LO];
      reg clr;
      // Clear select: none, clear 0 or clear 1
      always @* begin
        case (cs)
          2'h1:    clr = blk_clr[0];
          2'h2:    clr = blk_clr[1];
          default: clr = 1'b0;
        endcase
      end
      ptma_mc_reg u_reg (
        .aclk    (aclk),
        .aresetn (aresetn),
        .tick    (blk_tick[ck]),
        .clr     (clr),
        .regd    (cfg[`PTMA_MC_REGD]),
        .ff_type (cfg[`PTMA_MC_FF_HI:`PTMA_MC_FF_LO]),
        .d       (logic_out),
        .k       (t1),
        .q       (mc_q[m])
      );
    end
  endgenerate

  // Sixteen macrocell outputs
  always @* begin
    mc_out = mc_q;
  end

  // ************************************************************
  // AXI4-Lite write path
  // ************************************************************
  reg         aw_held;
  reg         w_held;
  reg  [11:0] aw_addr;
  reg  [31:0] w_data;
  reg  [3:0]  w_strb;
  wire [11:0] wa = aw_held ? aw_addr : s_axi_awaddr;
  wire [31:0] wd = w_held ? w_data : s_axi_wdata;
  wire [3:0]  ws = w_held ? w_strb : s_axi_wstrb;
  wire        aw_ok = aw_held | (s_axi_awvalid & s_axi_awready);
  wire        w_ok = w_held | (s_axi_wvalid & s_axi_wready);
  wire        do_wr = aw_ok & w_ok;
  reg         wr_mc;
  reg         wr_tm;
  reg         wr_ck;
  reg         wr_cl;
  wire        wr_hit = wr_mc | wr_tm | wr_ck | wr_cl;
  wire [31:0] bmask = {{8{ws[3]}}, {8{ws[2]}}, {8{ws[1]}}, {8{ws[0]}}};

  // Write target decode; any other address answers with an error
  always @* begin
    wr_mc = (wa < `PTMA_CLK_CFG);
    wr_tm = (wa >= `PTMA_TERM_BASE) && (wa <= `PTMA_TERM_END);
    wr_ck = (wa == `PTMA_CLK_CFG);
    wr_cl = (wa == `PTMA_CLR_CFG);
  end

  // Handshake, response and register update
  always @(posedge aclk) begin : wr_proc
    integer i;
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= 2'b00;
      aw_held       <= 1'b0;
      w_held        <= 1'b0;
      aw_addr       <= 12'h000;
      w_data        <= 32'h0000_0000;
      w_strb        <= 4'h0;
      clk_cfg       <= `PTMA_CLK_CFG_RST;
      clr_cfg       <= `PTMA_CLR_CFG_RST;
      for (i = 0; i < NMC; i = i + 1) begin
        mc_cfg[i] <= `PTMA_MC_CFG_RST;
      end
      for (i = 0; i < NW; i = i + 1) begin
        term_mem[i] <= `PTMA_TERM_RST;
      end
    end else begin
      s_axi_awready <= ~aw_ok & ~s_axi_bvalid & ~(s_axi_awvalid & s_axi_awready);
      s_axi_wready  <= ~w_ok & ~s_axi_bvalid & ~(s_axi_wvalid & s_axi_wready);
      if (s_axi_awvalid & s_axi_awready) begin
        aw_held <= ~do_wr;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid & s_axi_wready) begin
        w_held <= ~do_wr;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (do_wr) begin
        aw_held       <= 1'b0;
        w_held        <= 1'b0;
        s_axi_awready <= 1'b0;
        s_axi_wready  <= 1'b0;
        s_axi_bvalid  <= 1'b1;
        s_axi_bresp   <= wr_hit ? 2'b00 : 2'b10;
        if (wr_mc) begin
          mc_cfg[wa[5:2]] <= (mc_cfg[wa[5:2]] & ~bmask) | (wd & bmask);
        end
        if (wr_tm) begin
          term_mem[wa[8:2] - 7'h40] <= (term_mem[wa[8:2] - 7'h40] & ~bmask) | (wd & bmask);
        end
        if (wr_ck) begin
          clk_cfg <= (clk_cfg & ~bmask) | (wd & bmask);
        end
        if (wr_cl) begin
          clr_cfg <= (clr_cfg & ~bmask) | (wd & bmask);
        end
      end else if (s_axi_bvalid & s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // ************************************************************
  // AXI4-Lite read path
  // ************************************************************
  wire [11:0] ra = s_axi_araddr;
  reg  [31:0] next_rdata;
  reg  [1:0]  next_rresp;

  // Read data and response for the offered address
  always @* begin
    next_rdata = 32'h0000_0000;
    next_rresp = 2'b00;
    if (ra < `PTMA_CLK_CFG) begin
      next_rdata = mc_cfg[ra[5:2]];
    end else if (ra == `PTMA_CLK_CFG) begin
      next_rdata = clk_cfg;
    end else if (ra == `PTMA_CLR_CFG) begin
      next_rdata = clr_cfg;
    end else if (ra == `PTMA_STATUS) begin
      next_rdata = {{(32-NMC){1'b0}}, mc_q}; // Macrocell outputs
    end else if ((ra >= `PTMA_TERM_BASE) && (ra <= `PTMA_TERM_END)) begin
      next_rdata = term_mem[ra[8:2] - 7'h40];
    end else begin
      next_rresp = 2'b10; // Unmapped
    end
  end

  // Address accepted and answered one cycle later
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= 2'b00;
    end else if (s_axi_arvalid & s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rresp   <= next_rresp;
      s_axi_rdata   <= next_rdata;
    end else if (s_axi_rvalid) begin
      if (s_axi_rready) begin
        s_axi_rvalid  <= 1'b0;
      end
    end else begin
      s_axi_arready <= 1'b1;
    end
  end

endmodule

// [hw/ptma_map.vh]
`ifndef PTMA_MAP_VH
`define PTMA_MAP_VH

// ************************************************************
// Register byte offsets
// ************************************************************
`define PTMA_MC_CFG_BASE   12'h000
`define PTMA_CLK_CFG       12'h040
`define PTMA_CLR_CFG       12'h044
`define PTMA_STATUS        12'h048
`define PTMA_TERM_BASE     12'h100
`define PTMA_TERM_END      12'h2FC

// ************************************************************
// Macrocell configuration word fields
// ************************************************************
`define PTMA_MC_REGD       0
`define PTMA_MC_FF_LO      1
`define PTMA_MC_FF_HI      2
`define PTMA_MC_CLKSEL     3
`define PTMA_MC_CLR_LO     4
`define PTMA_MC_CLR_HI     5
`define PTMA_MC_INV1       6
`define PTMA_MC_LEND0      7
`define PTMA_MC_LEND1      8
`define PTMA_MC_PASS       9
`define PTMA_MC_TAKE       10
`define PTMA_MC_XOR        11

// ************************************************************
// Flip-flop kinds and clock sources
// ************************************************************
`define PTMA_FF_D          2'h0
`define PTMA_FF_T          2'h1
`define PTMA_FF_JK         2'h2
`define PTMA_FF_SR         2'h3
`define PTMA_SRC_PIN       2'h0
`define PTMA_SRC_GLB       2'h1
`define PTMA_SRC_LOC       2'h2

// ************************************************************
// Clock and clear configuration fields
// ************************************************************
`define PTMA_CK_SRC_W      4
`define PTMA_CK_FALL       2
`define PTMA_CL_LOCAL      0
`define PTMA_CL_INV        1
`define PTMA_CL_W          4

// ************************************************************
// Reset values
// ************************************************************
`define PTMA_MC_CFG_RST    32'h0000_0000
`define PTMA_CLK_CFG_RST   32'h0000_0000
`define PTMA_CLR_CFG_RST   32'h0000_0000
`define PTMA_TERM_RST      32'h0000_0000

`endif

// [hw/ptma_mc_reg.v]
`include "ptma_map.vh"

// Programmable macrocell storage element with bypass
module ptma_mc_reg (
  input  wire       aclk,
  input  wire       aresetn,
  input  wire       tick,
  input  wire       clr,
  input  wire       regd,
  input  wire [1:0] ff_type,
  input  wire       d,
  input  wire       k,
  output reg        q
);

  reg state;
  reg next_state;

  // Next state per flip-flop kind
  always @* begin
    case (ff_type)
      `PTMA_FF_D:  next_state = d;
      `PTMA_FF_T:  next_state = state ^ d;
      `PTMA_FF_JK: next_state = (d & ~state) | (~k & state);
      `PTMA_FF_SR: next_state = ~k & (d | state);
      default:     next_state = state;
    endcase
  end

  // Storage; clear wins over clock and enable
  always @(posedge aclk) begin
    if (!aresetn) begin
      state <= 1'b0;
    end else if (clr) begin
      state <= 1'b0;
    end else if (tick) begin
      state <= next_state;
    end
  end

  // Output stage: registered value or bypassed logic
  always @(posedge aclk) begin
    if (!aresetn) begin
      q <= 1'b0;
    end else if (regd) begin
      q <= (clr | ~tick) ? (clr ? 1'b0 : state) : next_state;
    end else begin
      q <= d;
    end
  end

endmodule

// [tb/ptma_array_sva.sv]
`include "ptma_map.vh"

module ptma_array_sva (
  input wire        aclk,
  input wire        aresetn,
  input wire [11:0] s_axi_awaddr,
  input wire        s_axi_awvalid,
  input wire        s_axi_awready,
  input wire        s_axi_wvalid,
  input wire        s_axi_wready,
  input wire [1:0]  s_axi_bresp,
  input wire        s_axi_bvalid,
  input wire        s_axi_bready,
  input wire [11:0] s_axi_araddr,
  input wire        s_axi_arvalid,
  input wire        s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire [1:0]  s_axi_rresp,
  input wire        s_axi_rvalid,
  input wire        s_axi_rready
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // ************************************************************
  // Handshake steps
  // ************************************************************
  sequence wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence rd_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence
  sequence b_done;
    s_axi_bvalid && s_axi_bready;
  endsequence
  sequence r_done;
    s_axi_rvalid && s_axi_rready;
  endsequence
  // ************************************************************
  // Register bus timing and refusals
  // ************************************************************
  a_wr_answer: assert property (wr_taken |=> s_axi_bvalid) else $error("write answer late");
  a_b_release: assert property (b_done |=> !s_axi_bvalid ##1 (s_axi_awready && s_axi_wready))
    else $error("write channel not reopened");
  a_b_busy: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while answer pending");
  a_wr_ro_err: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    && s_axi_awaddr == `PTMA_STATUS |=> s_axi_bresp == 2'h2) else $error("status write accepted");
  a_rd_answer: assert property (rd_taken |=> s_axi_rvalid) else $error("read answer late");
  a_r_release: assert property (r_done |=> !s_axi_rvalid ##1 s_axi_arready)
    else $error("read channel not reopened");
  a_r_busy: assert property (s_axi_rvalid |-> !s_axi_arready) else $error("read taken while busy");
  a_rd_unmapped: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr == 12'h04C
    |=> s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0000_0000) else $error("unmapped read accepted");
endmodule

bind ptma_array ptma_array_sva u_ptma_array_sva (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
  .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
  .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
  .s_axi_rready);

// [tb/ptma_fabric.sv]
module ptma_fabric (
  input  wire         aclk,
  output logic [31:0] local_in,
  output logic [1:0]  dev_clk_pin,
  output logic [1:0]  glb_sig,
  output logic [5:0]  loc_ctl
);
  timeunit 1ns;
  timeprecision 1ns;
  // Quiet fabric at time zero, local clock standing low
  initial begin
    local_in = 32'h0000_0000;
    dev_clk_pin = 2'h0;
    glb_sig = 2'h0;
    loc_ctl = 6'h00;
  end
  // New logic inputs just after an edge
  task automatic put_in(input logic [31:0] v);
    @(posedge aclk);
    local_in <= v;
  endtask
  // One local control line set just after an edge
  task automatic set_ctl(input int n, input logic v);
    @(posedge aclk);
    loc_ctl[n] <= v;
  endtask
  // One global line set just after an edge
  task automatic set_glb(input int n, input logic v);
    @(posedge aclk);
    glb_sig[n] <= v;
  endtask
  // Local clock 0 pulse, high for four cycles, then low for three
  task automatic pulse();
    set_ctl(0, 1'b1);
    repeat (3) @(posedge aclk);
    set_ctl(0, 1'b0);
    repeat (3) @(posedge aclk);
  endtask
endmodule

// [tb/product_term_macrocell_array_test.sv]
`include "ptma_map.vh"

module product_term_macrocell_array_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic [31:0] local_in, s_axi_rdata, v;
  logic [1:0]  dev_clk_pin, glb_sig, s_axi_bresp, s_axi_rresp;
  logic [5:0]  loc_ctl;
  logic [15:0] mc_out;
  logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
  logic [31:0] s_axi_wdata = 32'h0000_0000;
  logic [3:0]  s_axi_wstrb = 4'h0;
  logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic        s_axi_arvalid = 0, s_axi_rready = 0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [33:0] exp_q[$];
  logic [31:0] seed = 32'h0001_7025;
  int          errors = 0, n_tests = 0, cyc = 0;

  ptma_array u_ptma_array (.aclk, .aresetn, .local_in, .dev_clk_pin, .glb_sig, .loc_ctl, .mc_out,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
  ptma_fabric u_ptma_fabric (.aclk, .local_in, .dev_clk_pin, .glb_sig, .loc_ctl);

  // Clock at 20 MHz
  always #25 aclk = ~aclk;

  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // Status: mc0 sum, mc2 fed back from mc0, mc3 register
  function automatic logic [15:0] st(input logic [31:0] i, input logic q3);
    logic o;
    o = (i[0] & i[1]) | i[2] | i[4];
    return {12'h000, q3, o, 1'b0, o};
  endfunction
  task automatic chk(input logic [33:0] got, input logic [33:0] exp);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic stop_test();
    $display("errors %0d n_tests %0d", errors, n_tests);
    if (errors == 0 && n_tests > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // Write: address and data offered together, each dropped when taken
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
                    input logic [1:0] r);
    exp_q.push_back({r, 32'h0000_0000});
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    @(posedge aclk);
  endtask
  task automatic rd(input logic [11:0] a, input logic [33:0] e);
    exp_q.push_back(e);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    @(posedge aclk);
  endtask
  task automatic rs(input logic [15:0] e);
    rd(`PTMA_STATUS, {18'h0_0000, e});
  endtask

  // Scoreboard on answers, plus the hang limit
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      errors++;
      stop_test();
    end
    if (s_axi_bvalid && s_axi_bready) chk({s_axi_bresp, 32'h0000_0000}, exp_q.pop_front());
    if (s_axi_rvalid && s_axi_rready) chk({s_axi_rresp, s_axi_rdata}, exp_q.pop_front());
  end

  initial begin
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(`PTMA_MC_CFG_BASE, 34'h0_0000_0000);
    rs(16'h0000);
    rd(12'h04C, {2'h2, 32'h0000_0000});
    wr(`PTMA_STATUS, 32'hFFFF_FFFF, 4'hF, 2'h2);
    wr(12'h2F4, 32'hA5A5_A5A5, 4'h6, 2'h0);
    rd(12'h2F4, {2'h0, 32'h00A5_A500});
    wr(12'h2F4, 32'h0000_0000, 4'hF, 2'h0);
    wr(12'h100, 32'h0000_0003, 4'hF, 2'h0);
    wr(12'h114, 32'h0000_0004, 4'hF, 2'h0);
    wr(12'h120, 32'h0000_0010, 4'hF, 2'h0);
    wr(12'h148, 32'h0000_0001, 4'hF, 2'h0);
    wr(12'h004, 32'h0000_0080, 4'hF, 2'h0);
    wr(`PTMA_MC_CFG_BASE, 32'h0000_0440, 4'hF, 2'h0);
    for (int i = 0; i < 12; i++) begin
      v = xs();
      u_ptma_fabric.put_in(v);
      repeat (8) @(posedge aclk);
      rs(st(v, 1'b0));
    end
    wr(12'h160, 32'h0000_0100, 4'hF, 2'h0);
    wr(`PTMA_CLK_CFG, 32'h0000_0002, 4'hF, 2'h0);
    wr(`PTMA_CLR_CFG, 32'h0000_0001, 4'hF, 2'h0);
    wr(12'h00C, 32'h0000_0011, 4'hF, 2'h0);
    v = 32'h0000_0100;
    u_ptma_fabric.put_in(v);
    u_ptma_fabric.pulse();
    rs(st(v, 1'b0));
    u_ptma_fabric.set_ctl(2, 1'b1);
    u_ptma_fabric.pulse();
    rs(st(v, 1'b1));
    u_ptma_fabric.put_in(32'h0000_0000);
    repeat (8) @(posedge aclk);
    rs(st(32'h0000_0000, 1'b1));
    u_ptma_fabric.put_in(v);
    u_ptma_fabric.set_ctl(4, 1'b1);
    u_ptma_fabric.pulse();
    rs(st(v, 1'b0));
    u_ptma_fabric.set_ctl(4, 1'b0);
    u_ptma_fabric.pulse();
    rs(st(v, 1'b1));
    wr(`PTMA_CLR_CFG, 32'h0000_0003, 4'hF, 2'h0);
    repeat (4) @(posedge aclk);
    rs(st(v, 1'b0));
    // Clock 1 from global line 1 on its falling edge, enable 1
    wr(`PTMA_CLR_CFG, 32'h0000_0000, 4'hF, 2'h0);
    wr(`PTMA_CLK_CFG, 32'h0000_0052, 4'hF, 2'h0);
    wr(12'h00C, 32'h0000_0009, 4'hF, 2'h0);
    u_ptma_fabric.set_ctl(3, 1'b1);
    u_ptma_fabric.set_glb(1, 1'b1);
    repeat (4) @(posedge aclk);
    rs(st(v, 1'b0));
    u_ptma_fabric.set_glb(1, 1'b0);
    repeat (4) @(posedge aclk);
    rs(st(v, 1'b1));
    stop_test();
  end
endmodule
